/* src/spe_pkg.sv */
/*
 * Shared constants and types for the serial EEPROM slave: opcodes, status layout,
 * array geometry, protection decode and the program-cycle timing.
 * Assumes a 125 MHz system clock and an array of 128 bytes with 16-byte pages.
 */
package spe_pkg;

    localparam int ADDR_W = 7;
    localparam int MEM_BYTES = 128;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int BYTE_W = 8;

    // bit 3 of every opcode is a don't-care
    localparam logic [7:0] OPC_MASK = 8'hF7;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;

    // status byte field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BP_LO_BIT = 2;
    localparam int ST_BP_HI_BIT = 3;
    localparam logic [3:0] ST_UPPER_VAL = 4'h0;

    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic [7:0] MEM_RESET = 8'hFF;
    localparam logic [6:0] PROT_QUARTER_BASE = 7'h60;
    localparam logic [6:0] PROT_HALF_BASE = 7'h40;

    localparam int TWC_MAX_MS = 5;
    localparam int CLK_KHZ = 125000;
    // longest time: rounds down, here exact
    localparam int TWC_CYCLES = TWC_MAX_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        SEQ_CMD    = 3'b000,
        SEQ_ADDR   = 3'b001,
        SEQ_RDATA  = 3'b010,
        SEQ_WDATA  = 3'b011,
        SEQ_STOUT  = 3'b100,
        SEQ_STIN   = 3'b101,
        SEQ_LATCH  = 3'b110,
        SEQ_IGNORE = 3'b111
    } spe_seq_t;

    typedef struct packed {
        logic [3:0] upper;
        logic block_protect_hi;
        logic block_protect_lo;
        logic enable_latch_flag;
        logic program_busy_flag;
    } spe_status_t;

    function automatic logic spe_is_protected(input logic [1:0] bp, input logic [6:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (bp)
            2'h0: hit = 1'b0;
            2'h1: hit = (addr >= PROT_QUARTER_BASE);
            2'h2: hit = (addr >= PROT_HALF_BASE);
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

endpackage

/* src/spe_eeprom.sv */
/*
 * Serial EEPROM slave: prefetch FIFO and the top module with the command decoder,
 * read prefetch, page buffer, status byte, write latch and program timer.
 * Assumes all pins are synchronous to clk_sys and the serial clock runs far slower,
 * so that every serial edge is seen as a level change between two system clocks.
 */
// Function
// - bytes travel MSb first; instructions held in an 8-bit register.
// - input bit sampled on each rising serial clock while selected.
// - after pause release the sequence continues at the same bit.
// - read opcode then address byte, then stored data shifts out.
// - read pointer advances per byte and wraps from 7Fh to 00h.
// - select going high ends a sequential read.
// - latch set/clear opcodes act only if select rises after eight bits.
// - no internal write without the latch set before the instruction.
// - write is opcode, address, then one to 16 bytes in one page.
// - write loading bumps only the low four address bits, wrapping in page.
// - write commits only if select rises right after a full byte.
// - program cycle starts at select rise and lasts at most 5 ms.
// - array reads are refused while programming; status reads allowed.
// - the enable latch clears when a program cycle completes.
// - latch also clears on reset, clear opcode, writes, and low protect pin.
// - status read opcode answers at any time, even while programming.
// - status bits: busy, latch, two protect bits; upper four undefined.
// - busy flag is one during programming, zero otherwise, read-only.
// - latch flag follows set/clear opcodes regardless of protection.
// - protect bits written only by status write and kept nonvolatile; system reset here loads BP_RESET.
// - protect code selects none, upper quarter, upper half or all.
// - low protect pin refuses writes but a running cycle finishes.
// - output changes after falling clock, floats while deselected.
`timescale 1ns/1ps
`default_nettype none

module spe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // DEPTH must be a power of two: pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slot_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign out_data = slot_ff[rd_ptr_ff[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            slot_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule

module spe_eeprom #(
    parameter int PROG_CYCLES = spe_pkg::TWC_CYCLES,
    parameter int FIFO_WORDS = spe_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe
);
    import spe_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    logic sck_q_ff, sck_d_ff, cs_q_ff, cs_d_ff, si_q_ff, hold_q_ff, wp_q_ff;
    logic paused_ff;
    spe_seq_t seq_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [6:0] addr_ff;
    logic is_read_ff, latch_set_ff, wel_snap_ff, st_got_ff;
    logic [1:0] st_data_ff;
    logic wel_ff, busy_ff, prog_is_st_ff;
    logic [1:0] bp_ff;
    logic [2:0] prog_page_ff;
    logic [CNT_W-1:0] prog_cnt_ff;
    logic [7:0] mem_ff [MEM_BYTES];
    logic [7:0] pg_data_ff [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pg_valid_ff;
    logic fetch_on_ff;
    logic [6:0] fetch_ptr_ff;
    logic so_ff, so_oe_ff, out_live_ff;
    logic [6:0] out_sh_ff;

    logic sck_rise, sck_fall, cs_rise, active, rx_edge, tx_edge, byte_done;
    logic [7:0] rx_byte, opc;
    logic wr_go, st_go, set_go, clr_go, prog_done;
    logic fifo_flush, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data, tx_byte;
    spe_status_t status;

    // pins are already synchronous; one stage plus a delayed copy for edges
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sck_q_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            cs_q_ff <= 1'b1;
            cs_d_ff <= 1'b1;
            si_q_ff <= 1'b0;
            hold_q_ff <= 1'b1;
            wp_q_ff <= 1'b1;
        end else begin
            sck_q_ff <= sck;
            sck_d_ff <= sck_q_ff;
            cs_q_ff <= cs_n;
            cs_d_ff <= cs_q_ff;
            si_q_ff <= si;
            hold_q_ff <= hold_n;
            wp_q_ff <= wp_n;
        end
    end

    assign sck_rise = sck_q_ff && !sck_d_ff;
    assign sck_fall = !sck_q_ff && sck_d_ff;
    assign cs_rise = cs_q_ff && !cs_d_ff;
    assign active = !cs_q_ff && !paused_ff;
    assign rx_edge = active && sck_rise;
    assign tx_edge = active && sck_fall;
    assign rx_byte = {shift_ff[6:0], si_q_ff};
    assign byte_done = rx_edge && (bit_cnt_ff == 3'h7);
    assign opc = rx_byte & OPC_MASK;

    // pause only enters or leaves while the clock is low
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            paused_ff <= 1'b0;
        end else if (cs_q_ff) begin
            paused_ff <= 1'b0;
        end else if (!paused_ff && !hold_q_ff && !sck_q_ff) begin
            paused_ff <= 1'b1;
        end else if (paused_ff && hold_q_ff && !sck_q_ff) begin
            paused_ff <= 1'b0;
        end
    end

    // bit position frozen while paused, only deselect resets it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seq_ff <= SEQ_CMD;
            bit_cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            addr_ff <= 7'h00;
            is_read_ff <= 1'b0;
            latch_set_ff <= 1'b0;
            wel_snap_ff <= 1'b0;
            st_got_ff <= 1'b0;
            st_data_ff <= BP_RESET;
        end else if (cs_q_ff) begin
            seq_ff <= SEQ_CMD;
            bit_cnt_ff <= 3'h0;
        end else if (rx_edge) begin
            shift_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            // an extra bit after the latch opcode voids it
            if (seq_ff == SEQ_LATCH || (seq_ff == SEQ_STIN && st_got_ff)) begin
                seq_ff <= SEQ_IGNORE;
            end else if (bit_cnt_ff == 3'h7) begin
                unique case (seq_ff)
                    SEQ_CMD: begin
                        unique case (opc)
                            OPC_READ: begin
                                seq_ff <= busy_ff ? SEQ_IGNORE : SEQ_ADDR;
                                is_read_ff <= 1'b1;
                            end
                            OPC_WRITE: begin
                                seq_ff <= busy_ff ? SEQ_IGNORE : SEQ_ADDR;
                                is_read_ff <= 1'b0;
                                wel_snap_ff <= wel_ff;
                            end
                            OPC_SET_LATCH: begin
                                seq_ff <= SEQ_LATCH;
                                latch_set_ff <= 1'b1;
                            end
                            OPC_CLR_LATCH: begin
                                seq_ff <= SEQ_LATCH;
                                latch_set_ff <= 1'b0;
                            end
                            OPC_READ_STATUS: seq_ff <= SEQ_STOUT;
                            OPC_WRITE_STATUS: begin
                                seq_ff <= SEQ_STIN;
                                wel_snap_ff <= wel_ff;
                                st_got_ff <= 1'b0;
                            end
                            default: seq_ff <= SEQ_IGNORE;
                        endcase
                    end
                    SEQ_ADDR: begin
                        addr_ff <= rx_byte[6:0];
                        seq_ff <= is_read_ff ? SEQ_RDATA : SEQ_WDATA;
                    end
                    SEQ_WDATA: begin
                        addr_ff <= {addr_ff[6:4], addr_ff[3:0] + 4'h1};
                    end
                    SEQ_STIN: begin
                        st_data_ff <= rx_byte[ST_BP_HI_BIT:ST_BP_LO_BIT];
                        st_got_ff <= 1'b1;
                    end
                    default: seq_ff <= seq_ff;
                endcase
            end
        end
    end

    // load page bytes; later bytes on the same offset overwrite
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pg_valid_ff <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                pg_data_ff[i] <= 8'h00;
            end
        end else if (byte_done && seq_ff == SEQ_ADDR && !is_read_ff) begin
            pg_valid_ff <= '0;
        end else if (byte_done && seq_ff == SEQ_WDATA) begin
            pg_data_ff[addr_ff[3:0]] <= rx_byte;
            pg_valid_ff[addr_ff[3:0]] <= 1'b1;
        end
    end

    // commit only on a byte boundary; latch set beforehand
    // protected addresses refused; low protect pin refuses
    assign wr_go = cs_rise && seq_ff == SEQ_WDATA && bit_cnt_ff == 3'h0 && |pg_valid_ff &&
                   wel_snap_ff && wel_ff && wp_q_ff && !busy_ff &&
                   !spe_is_protected(bp_ff, addr_ff);
    assign st_go = cs_rise && seq_ff == SEQ_STIN && st_got_ff && bit_cnt_ff == 3'h0 &&
                   wel_snap_ff && wel_ff && wp_q_ff && !busy_ff;
    // latch opcodes act whatever the protection
    assign set_go = cs_rise && seq_ff == SEQ_LATCH && latch_set_ff;
    assign clr_go = cs_rise && seq_ff == SEQ_LATCH && !latch_set_ff;
    assign prog_done = busy_ff && prog_cnt_ff == '0;

    // self-timed cycle from the select rise
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
            prog_cnt_ff <= '0;
            prog_is_st_ff <= 1'b0;
            prog_page_ff <= 3'h0;
        end else if (wr_go || st_go) begin
            busy_ff <= 1'b1;
            prog_cnt_ff <= CNT_W'(PROG_CYCLES - 1);
            prog_is_st_ff <= st_go;
            prog_page_ff <= addr_ff[6:4];
        end else if (prog_done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            prog_cnt_ff <= prog_cnt_ff - 1'b1;
        end
    end

    // the array is written at the end so a refused read never sees half a page
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem_ff[i] <= MEM_RESET;
            end
        end else if (prog_done && !prog_is_st_ff) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pg_valid_ff[i]) begin
                    mem_ff[{prog_page_ff, 4'(i)}] <= pg_data_ff[i];
                end
            end
        end
    end

    // protect bits only via status write; reset stands in for stored value
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bp_ff <= BP_RESET;
        end else if (prog_done && prog_is_st_ff) begin
            bp_ff <= st_data_ff;
        end
    end

    // protect pin low clears the latch and wins over a set
    // completion clears it; a set in the same cycle still wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wel_ff <= 1'b0;
        end else if (!wp_q_ff) begin
            wel_ff <= 1'b0;
        end else if (set_go) begin
            wel_ff <= 1'b1;
        end else if (clr_go || wr_go || st_go || prog_done) begin
            wel_ff <= 1'b0;
        end
    end

    // status layout; busy follows the program timer
    assign status = '{upper: ST_UPPER_VAL, block_protect_hi: bp_ff[1],
                      block_protect_lo: bp_ff[0], enable_latch_flag: wel_ff,
                      program_busy_flag: busy_ff};

    // prefetch from the address onward, stalled by a full FIFO
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_on_ff <= 1'b0;
            fetch_ptr_ff <= 7'h00;
        end else if (byte_done && seq_ff == SEQ_ADDR && is_read_ff) begin
            fetch_on_ff <= 1'b1;
            fetch_ptr_ff <= rx_byte[6:0];
        end else if (cs_q_ff) begin
            fetch_on_ff <= 1'b0;
        end else if (fetch_on_ff && fifo_in_ready) begin
            // seven-bit pointer rolls 7Fh to 00h
            fetch_ptr_ff <= fetch_ptr_ff + 7'h01;
        end
    end

    assign fifo_flush = cs_rise || (byte_done && seq_ff == SEQ_ADDR);
    assign fifo_pop = tx_edge && seq_ff == SEQ_RDATA && bit_cnt_ff == 3'h0;

    spe_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_WORDS)
    ) u_prefetch (
        .clk(clk_sys),
        .rst(sys_rst),
        .flush(fifo_flush),
        .in_valid(fetch_on_ff),
        .in_ready(fifo_in_ready),
        .in_data(mem_ff[fetch_ptr_ff]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // a late prefetch would need a clock far faster than the link allows
    assign tx_byte = (seq_ff == SEQ_STOUT) ? status :
                     (fifo_out_valid ? fifo_out_data : MEM_RESET);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            so_ff <= 1'b0;
            out_sh_ff <= 7'h00;
            out_live_ff <= 1'b0;
        end else if (cs_q_ff) begin
            out_live_ff <= 1'b0;
        end else if (tx_edge && (seq_ff == SEQ_RDATA || seq_ff == SEQ_STOUT)) begin
            out_live_ff <= 1'b1;
            if (bit_cnt_ff == 3'h0) begin
                so_ff <= tx_byte[7];
                out_sh_ff <= tx_byte[6:0];
            end else begin
                so_ff <= out_sh_ff[6];
                out_sh_ff <= {out_sh_ff[5:0], 1'b0};
            end
        end
    end

    // float when deselected; a low pause pin floats at once
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            so_oe_ff <= 1'b0;
        end else begin
            so_oe_ff <= out_live_ff && !cs_q_ff && hold_q_ff && !paused_ff;
        end
    end

    assign so = so_ff;
    assign so_oe = so_oe_ff;

    chk_so_float_desel: assert property (
        @(posedge clk_sys) disable iff (sys_rst) cs_q_ff |=> !so_oe_ff)
        else $error("output enabled while deselected");

    chk_read_busy_refused: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        byte_done && seq_ff == SEQ_CMD && busy_ff && opc == OPC_READ |=> seq_ff == SEQ_IGNORE)
        else $error("array read accepted during programming");

    chk_page_wrap_low: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        byte_done && seq_ff == SEQ_WDATA && addr_ff[3:0] == 4'hF
        |=> addr_ff[3:0] == 4'h0 && $stable(addr_ff[6:4]))
        else $error("page offset did not wrap in page");

    chk_read_ptr_wrap: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        fetch_on_ff && fifo_in_ready && !cs_q_ff && fetch_ptr_ff == 7'h7F &&
        !(byte_done && seq_ff == SEQ_ADDR) |=> fetch_ptr_ff == 7'h00)
        else $error("read pointer did not wrap to zero");

    chk_prog_busy_min: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_go || st_go) |=> busy_ff [*8])
        else $error("program cycle shorter than expected");

    chk_prog_needs_wel: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(busy_ff) |-> $past(wel_ff) && $past(wel_snap_ff))
        else $error("program cycle started without enable latch");

    chk_wel_after_prog: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(busy_ff) && !$past(set_go) |-> !wel_ff)
        else $error("enable latch survived program completion");

    chk_wel_wp_low: assert property (
        @(posedge clk_sys) disable iff (sys_rst) !wp_q_ff |=> !wel_ff)
        else $error("enable latch set while protect pin low");

    chk_pause_frozen: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        paused_ff && !cs_q_ff |=> $stable(bit_cnt_ff) && $stable(shift_ff))
        else $error("serial position moved while paused");

    chk_latch_set_cmd: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        set_go && wp_q_ff |=> wel_ff ##1
        (wel_ff || $past(!wp_q_ff || clr_go || st_go || wr_go || prog_done)))
        else $error("latch set opcode did not set latch");

endmodule

`default_nettype wire

/* verif/spe_host_model.sv */
/*
 * Host-side serial master model driving the eeprom slave pins.
 * Assumes the bench calls its tasks and that clk is the slave's system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module spe_host_model (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic sel();
        cs_n <= 1'b0;
        wt(2);
    endtask
    task automatic desel();
        sck <= 1'b0;
        wt(2);
        cs_n <= 1'b1;
        wt(4);
    endtask
    // msb first, pause with clock low
    task automatic xfer(input logic [7:0] tx, input int pz, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            wt(4);
            if (i == pz) begin
                hold_n <= 1'b0;
                wt(6);
                hold_n <= 1'b1;
                wt(4);
            end
            // undriven line reads high through the pull-up
            rx[i] = so_oe ? so : 1'b1;
            sck <= 1'b1;
            wt(3);
        end
    endtask
endmodule
`default_nettype wire

/* verif/spe_eeprom_tb_top.sv */
/*
 * Self-checking bench for the serial eeprom slave with a host model.
 * Assumes the slave samples pins on clk_sys and reads back FFh after reset.
 */
`timescale 1ns/1ps
`default_nettype none
module spe_eeprom_tb_top;
    import spe_pkg::*;
    localparam int PROG = 200;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe;
    int failures = 0;
    int checked = 0;
    logic [31:0] rs = 32'h0006_4f25;
    logic [7:0] mem [128];
    logic [7:0] rx;
    always #4 clk_sys = ~clk_sys;
    spe_eeprom #(.PROG_CYCLES(PROG), .FIFO_WORDS(32)) i_spe_eeprom (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so(so), .so_oe(so_oe));
    spe_host_model i_spe_host_model (.clk(clk_sys), .so(so), .so_oe(so_oe), .cs_n(cs_n),
        .sck(sck), .si(si), .hold_n(hold_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic bx(input logic [7:0] tx, input int pz);
        i_spe_host_model.xfer(tx, pz, rx);
    endtask
    task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] d);
        i_spe_host_model.sel();
        bx(op, 8);
        if (n > 0) bx(d, 8);
        i_spe_host_model.desel();
    endtask
    // pausing mid-opcode must not disturb the status read
    task automatic rdst(input logic [7:0] exp);
        i_spe_host_model.sel();
        bx(OPC_READ_STATUS, 3);
        bx(8'h00, 8);
        i_spe_host_model.desel();
        chk(rx, exp, "status");
    endtask
    // poll busy instead of a fixed wait
    task automatic waitrdy();
        do begin
            i_spe_host_model.sel();
            bx(OPC_READ_STATUS, 8);
            bx(8'h00, 8);
            i_spe_host_model.desel();
        end while (rx[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic wrarr(input logic [7:0] a, input int n, input bit ok);
        logic [7:0] d;
        logic [3:0] lo;
        i_spe_host_model.sel();
        bx(OPC_WRITE, 8);
        bx(a, 5);
        lo = a[3:0];
        for (int k = 0; k < n; k++) begin
            rs = xs(rs);
            d = rs[7:0];
            bx(d, 8);
            if (ok) mem[{a[6:4], lo}] = d;
            lo = lo + 4'h1;
        end
        i_spe_host_model.desel();
    endtask
    task automatic rdarr(input logic [7:0] a, input int n);
        i_spe_host_model.sel();
        bx(OPC_READ, 8);
        bx(a, 8);
        for (int k = 0; k < n; k++) begin
            bx(8'h00, 8);
            chk(rx, mem[(int'(a[6:0]) + k) % 128], "array");
        end
        i_spe_host_model.desel();
    endtask
    task automatic end_sim();
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
    initial begin
        foreach (mem[i]) mem[i] = MEM_RESET;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rdst(8'h00);
        cmd(OPC_SET_LATCH, 0, 8'h00);
        rdst(8'h02);
        cmd(OPC_CLR_LATCH, 0, 8'h00);
        rdst(8'h00);
        cmd(8'h86, 0, 8'h00);
        rdst(8'h00);
        cmd(OPC_SET_LATCH, 1, 8'h55);
        rdst(8'h00);
        cmd(OPC_SET_LATCH, 0, 8'h00);
        wrarr(8'h9A, 20, 1'b1);
        rdst(8'h01);
        waitrdy();
        rdst(8'h00);
        rdarr(8'h10, 16);
        rdarr(8'h7E, 20);
        // bit 3 of the opcode is a don't-care
        cmd(OPC_SET_LATCH | 8'h08, 0, 8'h00);
        wrarr(8'h05, 0, 1'b0);
        rdst(8'h02);
        cmd(OPC_WRITE_STATUS, 1, 8'h04);
        repeat (PROG) @(posedge clk_sys);
        rdst(8'h04);
        cmd(OPC_SET_LATCH, 0, 8'h00);
        wrarr(8'h65, 1, 1'b0);
        rdst(8'h06);
        wrarr(8'h25, 2, 1'b1);
        // array read while programming must stay silent
        i_spe_host_model.sel();
        bx(OPC_READ, 8);
        bx(8'h10, 8);
        bx(8'h00, 8);
        i_spe_host_model.desel();
        chk(rx, 8'hFF, "busy read");
        repeat (PROG) @(posedge clk_sys);
        cmd(OPC_SET_LATCH, 0, 8'h00);
        wp_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rdst(8'h04);
        wp_n <= 1'b1;
        rdarr(8'h20, 8);
        rdarr(8'h60, 8);
        end_sim();
    end
endmodule
`default_nettype wire
